// *** hw/pmu_pkg.sv ***
// constants, carrier structs and state types of the power sequencer and its serial port
// assumes one 50 MHz clock; every analog comparator reaches the block as a raw level
package pmu_pkg;
   localparam int          CLK_HZ        = 50_000_000;
   localparam int          RESET_TIME_MS = 40;
   localparam int          RESET_CYCLES  = CLK_HZ / 1000 * RESET_TIME_MS;
   localparam int          TIMER_W       = 22;
   localparam int          SCL_MAX_KHZ   = 400;
   localparam logic [6:0]  SLAVE_ADDR    = 7'h5A;
   localparam logic [7:0]  REG_SYSTEM    = 8'h00;
   localparam logic [7:0]  REG_STATUS    = 8'h01;
   localparam logic [7:0]  REG_SRC_INDEX = 8'hC1;
   localparam logic [3:0]  CODE_RESET    = 4'h0;
   localparam int          CODE_EN_BIT   = 3;
   localparam int          SYS_TH_UNMASK = 4;
   localparam int          SYS_SL_UNMASK = 5;
   localparam int          NUM_BLOCKS    = 9;
   // index 0 is the system block, then buck_a..c, four ldos, path_charger, otg
   localparam logic [7:0]  SRC_CODES [0:NUM_BLOCKS] = '{8'h00, 8'h10, 8'h20, 8'h30,
      8'h50, 8'h60, 8'h70, 8'h80, 8'hA0, 8'hB0};

   typedef struct packed {
      logic master_power_enable;
      logic scl;
      logic sda;
      logic sys_uvlo_ok;
      logic sys_3v45_ok;
      logic ka_good;
      logic ka_low;
      logic buck_a_pgood;
      logic below_thr;
      logic temp_warn;
      logic temp_shut;
      logic temp_recov;
   } sense_type;

   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_REG, I_WDATA, I_ACK, I_TX, I_TXACK
   } i2c_state_type;

   typedef struct packed {
      sense_type            s1;
      sense_type            s2;
      sense_type            s3;
      i2c_state_type        st;
      i2c_state_type        nx;
      logic [3:0]           bits;
      logic [7:0]           sh;
      logic [7:0]           ptr;
      logic                 sda_oe;
      logic [3:0]           code;
      logic                 th_unmask;
      logic                 sl_unmask;
      logic                 sl_pend;
      logic                 th_pend;
      logic                 th_lock;
      logic                 ka_en;
      logic                 bucks_en;
      logic                 ldo_en;
      logic                 other_en;
      logic                 released;
      logic                 irq;
      logic [TIMER_W-1:0]   timer;
   } state_type;
endpackage

// *** hw/pmu_sequencer_irq_control.sv ***
// power sequencer, reset timer, interrupt gathering and register port of the pmu
// assumes raw comparator levels and i2c pins from outside; block_irq_i from same-clock logic
// Functional notes
// - master enable high turns on buck_a, buck_b, buck_c and ldo_a.
// - master enable low turns off all regulators except keepalive_ldo.
// - keepalive below 1.67V pulls the reset output low.
// - reset released after 40ms timer expiry with buck_a power-good.
// - interrupt output pulled low whenever any unmasked interrupt is pending.
// - interrupt sources masked after reset; host unmasks them over the serial port.
// - supply above lockout or keepalive good enables keepalive and holds reset low.
// - step-down converters enabled only with master enable and supply above 3.45V.
// - buck_a power-good enables ldo_a and starts the 40ms reset delay.
// - re-enabling after shutdown restores regulators; reset stays released.
// - serial port is an i2c slave only, up to 400kHz clock.
// - device answers slave address 1011010 plus a read/write bit.
// - single-byte register writes and single-byte register reads are supported.
// - bytes are eight bits, msb first, sampled on rising scl, then acknowledged.
// - host reads source index then the source's bits to service an interrupt.
// - source index register returns a fixed code per interrupting block.
// - supply monitor off by default, enabled by threshold codes 1000 to 1111.
// - supply-low flag reads 1 while supply is below the selected threshold.
// - supply-low interrupt raised only when its unmask bit is 1.
// - thermal interrupt raised at 120C indication when thermal unmask is 1.
// - above 160C all regulators except keepalive_ldo off until temperature falls by 20C.
`timescale 1ns/10ps
module pmu_sequencer_irq_control
   import pmu_pkg::*;
#(
   parameter int RST_CYCLES = RESET_CYCLES
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // control pin
   input  wire logic                  master_power_enable_i,
   // i2c pins
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe_o,
   // analog comparator levels
   input  wire logic                  sys_uvlo_ok_i,
   input  wire logic                  sys_3v45_ok_i,
   input  wire logic                  keepalive_good_i,
   input  wire logic                  keepalive_low_i,
   input  wire logic                  buck_a_pgood_i,
   input  wire logic                  supply_below_thr_i,
   input  wire logic                  temp_warn_i,
   input  wire logic                  temp_shutdown_i,
   input  wire logic                  temp_recovered_i,
   // interrupt requests of the other blocks, already masked there
   input  wire logic [NUM_BLOCKS-1:0] block_irq_i,
   // regulator enables
   output logic                       buck_a_en_o,
   output logic                       buck_b_en_o,
   output logic                       buck_c_en_o,
   output logic                       ldo_a_en_o,
   output logic                       other_regs_allow_o,
   output logic                       keepalive_ldo_en_o,
   // supply monitor
   output logic [3:0]                 supply_threshold_code_o,
   output logic                       supply_monitor_en_o,
   // open-drain outputs
   output logic                       power_on_reset_out_n_o,
   output logic                       power_on_reset_out_n_oe_o,
   output logic                       interrupt_out_n_o,
   output logic                       interrupt_out_n_oe_o
);

   state_type r;
   state_type n;
   sense_type raw;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic       sl_flag;
   logic       sys_irq;
   logic [7:0] src_idx;
   logic [7:0] rd_data;
   logic       bucks_c;

   assign raw = '{master_power_enable: master_power_enable_i, scl: scl_i, sda: sda_i,
                  sys_uvlo_ok: sys_uvlo_ok_i, sys_3v45_ok: sys_3v45_ok_i,
                  ka_good: keepalive_good_i, ka_low: keepalive_low_i,
                  buck_a_pgood: buck_a_pgood_i, below_thr: supply_below_thr_i,
                  temp_warn: temp_warn_i, temp_shut: temp_shutdown_i,
                  temp_recov: temp_recovered_i};

   // edges only from the second and third stages
   assign scl_rise = r.s2.scl & ~r.s3.scl;
   assign scl_fall = ~r.s2.scl & r.s3.scl;
   assign start_c  = r.s2.scl & r.s3.scl & r.s3.sda & ~r.s2.sda;
   assign stop_c   = r.s2.scl & r.s3.scl & ~r.s3.sda & r.s2.sda;

   // monitor is live only while the top code bit is set
   assign sl_flag = r.code[CODE_EN_BIT] & r.s2.below_thr;
   assign sys_irq = (r.sl_pend & r.sl_unmask) | (r.th_pend & r.th_unmask);

   assign bucks_c = r.ka_en & r.s2.master_power_enable & r.s2.sys_3v45_ok & ~r.th_lock;

   // system first, then the lowest-numbered block
   always_comb begin
      src_idx = SRC_CODES[0];
      for (int i = NUM_BLOCKS - 1; i >= 0; i--) begin
         if (block_irq_i[i]) begin
            src_idx = SRC_CODES[i+1];
         end
      end
      if (sys_irq) begin
         src_idx = SRC_CODES[0];
      end
   end

   always_comb begin
      if (r.ptr == REG_SYSTEM) begin
         rd_data = {2'h0, r.sl_unmask, r.th_unmask, r.code};
      end else if (r.ptr == REG_STATUS) begin
         rd_data = {4'h0, r.th_lock, r.th_pend, r.sl_pend, sl_flag};
      end else if (r.ptr == REG_SRC_INDEX) begin
         rd_data = src_idx;
      end else begin
         rd_data = 8'h00;
      end
   end

   always_comb begin
      n    = r;
      n.s1 = raw;
      n.s2 = r.s1;
      n.s3 = r.s2;

      // serial slave; it only ever answers, never drives scl
      if (stop_c) begin
         n.st     = I_IDLE;
         n.sda_oe = 1'b0;
      end else if (start_c) begin
         n.st     = I_ADDR;
         n.bits   = 4'h0;
         n.sda_oe = 1'b0;
      end else begin
         case (r.st)
            I_IDLE: begin
               n.bits = 4'h0;
            end
            I_ADDR, I_REG, I_WDATA: begin
               if (scl_rise) begin
                  n.sh   = {r.sh[6:0], r.s2.sda};
                  n.bits = r.bits + 4'h1;
               end else if (scl_fall && r.bits == 4'h8) begin
                  n.sda_oe = 1'b1;
                  n.st     = I_ACK;
                  if (r.st == I_ADDR) begin
                     if (r.sh[7:1] == SLAVE_ADDR) begin
                        n.nx = r.sh[0] ? I_TX : I_REG;
                     end else begin
                        n.sda_oe = 1'b0;
                        n.st     = I_IDLE;
                     end
                  end else if (r.st == I_REG) begin
                     n.ptr = r.sh;
                     n.nx  = I_WDATA;
                  end else begin
                     n.nx = I_WDATA;
                     if (r.ptr == REG_SYSTEM) begin
                        n.code      = r.sh[3:0];
                        n.th_unmask = r.sh[SYS_TH_UNMASK];
                        n.sl_unmask = r.sh[SYS_SL_UNMASK];
                     end
                  end
               end
            end
            I_ACK: begin
               if (scl_fall) begin
                  n.sda_oe = 1'b0;
                  n.bits   = 4'h0;
                  n.st     = r.nx;
                  if (r.nx == I_TX) begin
                     n.sh     = rd_data;
                     n.sda_oe = ~rd_data[7];
                     // reading status clears pending flags
                     if (r.ptr == REG_STATUS) begin
                        n.sl_pend = 1'b0;
                        n.th_pend = 1'b0;
                     end
                  end
               end
            end
            I_TX: begin
               if (scl_rise) begin
                  n.bits = r.bits + 4'h1;
               end else if (scl_fall) begin
                  if (r.bits == 4'h8) begin
                     n.sda_oe = 1'b0;
                     n.st     = I_TXACK;
                  end else begin
                     n.sh     = {r.sh[6:0], 1'b0};
                     n.sda_oe = ~r.sh[6];
                  end
               end
            end
            I_TXACK: begin
               if (scl_rise) begin
                  n.nx = I_TX;
                  n.st = r.s2.sda ? I_IDLE : I_ACK;
               end
            end
            default: begin
               n.st = I_IDLE;
            end
         endcase
      end

      // set wins over a read clear in the same cycle
      if (sl_flag) begin
         n.sl_pend = 1'b1;
      end
      if (r.s2.temp_warn) begin
         n.th_pend = 1'b1;
      end

      if (r.s2.temp_shut) begin
         n.th_lock = 1'b1;
      end else if (r.s2.temp_recov) begin
         n.th_lock = 1'b0;
      end

      if (r.s2.sys_uvlo_ok || r.s2.ka_good) begin
         n.ka_en = 1'b1;
      end

      n.bucks_en = bucks_c;
      n.ldo_en   = bucks_c & r.s2.buck_a_pgood;
      n.other_en = r.ka_en & r.s2.master_power_enable & ~r.th_lock;
      n.irq      = sys_irq | (|block_irq_i);

      // reset release survives master enable toggles while keepalive holds
      if (r.s2.ka_low || !r.ka_en) begin
         n.released = 1'b0;
         n.timer    = '0;
      end else if (!r.released) begin
         if (r.ldo_en && r.s2.buck_a_pgood) begin
            n.timer = r.timer + TIMER_W'(1);
            if (r.timer == TIMER_W'(RST_CYCLES - 1)) begin
               n.released = 1'b1;
            end
         end else begin
            n.timer = '0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign sda_o                     = 1'b0;
   assign sda_oe_o                  = r.sda_oe;
   assign buck_a_en_o               = r.bucks_en;
   assign buck_b_en_o               = r.bucks_en;
   assign buck_c_en_o               = r.bucks_en;
   assign ldo_a_en_o                = r.ldo_en;
   assign other_regs_allow_o        = r.other_en;
   assign keepalive_ldo_en_o        = r.ka_en;
   assign supply_threshold_code_o   = r.code;
   assign supply_monitor_en_o       = r.code[CODE_EN_BIT];
   assign power_on_reset_out_n_o    = 1'b0;
   assign power_on_reset_out_n_oe_o = ~r.released;
   assign interrupt_out_n_o         = 1'b0;
   assign interrupt_out_n_oe_o      = r.irq;

endmodule

// *** verification/pmu_seq_checker.sv ***
// concurrent checks on the sequencer pins
// assumes a bind onto pmu_sequencer_irq_control, seeing its ports only
`timescale 1ns/10ps
module pmu_seq_checker
   import pmu_pkg::*;
#(
   parameter int RST_CYCLES = 50
) (
   // clock and reset
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   // pins in
   input wire logic                  master_power_enable_i,
   input wire logic                  sys_3v45_ok_i,
   input wire logic                  keepalive_low_i,
   input wire logic                  temp_shutdown_i,
   input wire logic [NUM_BLOCKS-1:0] block_irq_i,
   // pins out
   input wire logic                  buck_a_en_o,
   input wire logic                  buck_b_en_o,
   input wire logic                  buck_c_en_o,
   input wire logic                  ldo_a_en_o,
   input wire logic                  power_on_reset_out_n_oe_o,
   input wire logic                  interrupt_out_n_oe_o
);
   int unsigned on_cnt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // six cycles cover the input sync plus the output register
   sequence s_pwr_off;
      !master_power_enable_i [*6];
   endsequence
   sequence s_hot;
      temp_shutdown_i [*6];
   endsequence
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         on_cnt <= 0;
      else
         on_cnt <= ldo_a_en_o ? on_cnt + 1 : 0;
   end
   AST_PWR_OFF: assert property (s_pwr_off |-> !buck_a_en_o && !ldo_a_en_o)
      else $error("regulator on with enable low");
   AST_BUCKS_TOGETHER: assert property (buck_a_en_o == buck_b_en_o && buck_b_en_o == buck_c_en_o)
      else $error("step-down enables differ");
   AST_LOW_SUPPLY: assert property (!sys_3v45_ok_i [*6] |-> !buck_a_en_o)
      else $error("step-down on with low supply");
   AST_LDO_AFTER_BUCK: assert property (ldo_a_en_o |-> buck_a_en_o)
      else $error("ldo on without buck");
   AST_KA_LOW_RESET: assert property (keepalive_low_i [*6] |-> power_on_reset_out_n_oe_o)
      else $error("reset free with keepalive low");
   // two cycles of slack for the output register and count start
   AST_RESET_DELAY: assert property ($fell(power_on_reset_out_n_oe_o) |-> on_cnt >= RST_CYCLES - 2)
      else $error("reset released early");
   AST_IRQ_BLOCK: assert property (|block_irq_i |=> interrupt_out_n_oe_o)
      else $error("interrupt line not pulled");
   AST_HOT_OFF: assert property (s_hot |-> !buck_a_en_o && !ldo_a_en_o)
      else $error("regulator on while overheated");
endmodule
bind pmu_sequencer_irq_control pmu_seq_checker #(.RST_CYCLES(RST_CYCLES)) chk (.*);

// *** verification/host_i2c.sv ***
// i2c host model: drives scl and its share of sda, reads the wire
// assumes a pull-up on sda; the bench ands in the device's pull-down
`timescale 1ns/10ps
module host_i2c
   import pmu_pkg::*;
(
   // wire
   input wire logic sda_i,
   output logic     scl_o,
   output logic     sda_o
);
   initial begin
      scl_o = 1'h1;
      sda_o = 1'h1;
   end
   // 160 ns per bit, scl stands high between frames
   task automatic bit_io(input logic b, output logic r);
      #20 sda_o = b;
      #60 scl_o = 1'h1;
      #76 r = sda_i;
      #4 scl_o = 1'h0;
   endtask
   task automatic start;
      #20 sda_o = 1'h1;
      #40 scl_o = 1'h1;
      #80 sda_o = 1'h0;
      #80 scl_o = 1'h0;
   endtask
   task automatic stop;
      #20 sda_o = 1'h0;
      #60 scl_o = 1'h1;
      #80 sda_o = 1'h1;
      #80;
   endtask
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(1'h1, a);
      ack = !a;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ra, wd, output logic acked);
      logic [7:0] rx;
      logic a0, a1, a2;
      start;
      xbyte({dev, 1'h0}, rx, a0);
      xbyte(ra, rx, a1);
      xbyte(wd, rx, a2);
      stop;
      acked = a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] ra, output logic [7:0] rd_o);
      logic [7:0] rx;
      logic a;
      start;
      xbyte({SLAVE_ADDR, 1'h0}, rx, a);
      xbyte(ra, rx, a);
      start;
      xbyte({SLAVE_ADDR, 1'h1}, rx, a);
      // a single byte, ended by a nack
      xbyte(8'hFF, rd_o, a);
      stop;
   endtask
endmodule

// *** verification/pmu_sequencer_irq_control_test.sv ***
// self-checking bench of the power sequencer with an i2c host model
// assumes pmu_pkg, the host model and the checker are compiled first
`timescale 1ns/10ps
module pmu_sequencer_irq_control_test
   import pmu_pkg::*;
;
   localparam int RST = 50;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   sense_type sn = '0;
   logic [NUM_BLOCKS-1:0] blk = '0;
   logic sda_oe, scl, sda_m, buck_a, buck_b, buck_c, ldo_a, ka_en;
   logic rst_oe, irq_oe, other, mon_en, ack;
   logic [3:0] code;
   logic [7:0] rdv;
   int bad_count = 0;
   int samples_checked = 0;
   int code_m;
   wire sda = sda_m & ~sda_oe;
   wire [5:0] rails = {ka_en, buck_a, buck_b, buck_c, ldo_a, rst_oe};
   always #10 clk_i = ~clk_i;
   pmu_sequencer_irq_control #(.RST_CYCLES(RST)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .master_power_enable_i(sn.master_power_enable),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
      .sys_uvlo_ok_i(sn.sys_uvlo_ok), .sys_3v45_ok_i(sn.sys_3v45_ok),
      .keepalive_good_i(sn.ka_good), .keepalive_low_i(sn.ka_low),
      .buck_a_pgood_i(sn.buck_a_pgood), .supply_below_thr_i(sn.below_thr),
      .temp_warn_i(sn.temp_warn), .temp_shutdown_i(sn.temp_shut),
      .temp_recovered_i(sn.temp_recov), .block_irq_i(blk),
      .buck_a_en_o(buck_a), .buck_b_en_o(buck_b), .buck_c_en_o(buck_c),
      .ldo_a_en_o(ldo_a), .other_regs_allow_o(other), .keepalive_ldo_en_o(ka_en),
      .supply_threshold_code_o(code), .supply_monitor_en_o(mon_en),
      .power_on_reset_out_n_o(), .power_on_reset_out_n_oe_o(rst_oe),
      .interrupt_out_n_o(), .interrupt_out_n_oe_o(irq_oe));
   host_i2c host (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic reg_is(input logic [7:0] ra, exp);
      // host pin edges land 5 ns past a clock edge, never on it
      #5;
      host.rd(ra, rdv);
      check(rdv, exp);
      cyc(1);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // lowest pending block wins; codes skip 0x40 and 0x90
   function automatic logic [7:0] src_model(input logic [NUM_BLOCKS-1:0] v);
      src_model = 8'h00;
      for (int i = NUM_BLOCKS - 1; i >= 0; i--)
         if (v[i])
            src_model = 8'((i + 1 + (i > 2) + (i > 6)) * 'h10);
   endfunction
   initial begin
      #1_000_000;
      bad_count++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(95));
      cyc(10);
      rst_i <= 1'h0;
      cyc(8);
      check(rails, 6'h01);
      check(irq_oe, 1'h0);
      sn.sys_uvlo_ok <= 1'h1;
      sn.ka_good <= 1'h1;
      sn.sys_3v45_ok <= 1'h1;
      sn.master_power_enable <= 1'h1;
      cyc(8);
      check(rails, 6'h3D);
      sn.buck_a_pgood <= 1'h1;
      cyc(RST);
      check({ldo_a, rst_oe}, 2'h3);
      cyc(12);
      check(rst_oe, 1'h0);
      done("power up");
      sn.master_power_enable <= 1'h0;
      cyc(8);
      check(rails, 6'h20);
      sn.master_power_enable <= 1'h1;
      cyc(8);
      check(rails, 6'h3E);
      done("restart");
      reg_is(REG_SYSTEM, 8'h00);
      reg_is(8'h55, 8'h00);
      #5;
      host.wr(7'h5B, REG_SYSTEM, 8'h3F, ack);
      check(ack, 1'h0);
      cyc(1);
      sn.temp_warn <= 1'h1;
      cyc(10);
      check(irq_oe, 1'h0);
      code_m = 8 + $urandom % 8;
      #5;
      host.wr(SLAVE_ADDR, REG_SYSTEM, 8'(8'h30 | code_m), ack);
      check(ack, 1'h1);
      cyc(4);
      check({mon_en, code}, 5'(5'h10 | code_m));
      check(irq_oe, 1'h1);
      reg_is(REG_SRC_INDEX, 8'h00);
      reg_is(REG_SYSTEM, 8'(8'h30 | code_m));
      sn.temp_warn <= 1'h0;
      cyc(6);
      reg_is(REG_STATUS, 8'h04);
      reg_is(REG_STATUS, 8'h00);
      check(irq_oe, 1'h0);
      sn.below_thr <= 1'h1;
      cyc(6);
      check(irq_oe, 1'h1);
      reg_is(REG_STATUS, 8'h03);
      sn.below_thr <= 1'h0;
      cyc(6);
      reg_is(REG_STATUS, 8'h02);
      reg_is(REG_STATUS, 8'h00);
      done("registers");
      for (int i = 0; i < NUM_BLOCKS; i++) begin
         blk <= 9'(($urandom << (i + 1)) | (1 << i));
         cyc(2);
         check(irq_oe, 1'h1);
         reg_is(REG_SRC_INDEX, src_model(blk));
      end
      blk <= '0;
      done("sources");
      sn.temp_shut <= 1'h1;
      cyc(8);
      check({buck_a, ldo_a, other}, 3'h0);
      sn.temp_shut <= 1'h0;
      cyc(8);
      check(buck_a, 1'h0);
      sn.temp_recov <= 1'h1;
      cyc(8);
      check({buck_a, ldo_a}, 2'h3);
      sn.ka_low <= 1'h1;
      cyc(8);
      check(rst_oe, 1'h1);
      sn.ka_low <= 1'h0;
      cyc(RST + 12);
      check(rst_oe, 1'h0);
      done("thermal and keepalive");
      tally_and_finish;
   end
endmodule
